// ==== apc_codec_model.sv ====
// Codec model: supplies transmit high clock, bit clock and frame sync pins.
// Assumes enables change only between bursts; clocks idle low when stopped.
`timescale 1ns/1ps
module apc_codec_model (
   input  wire logic hclk_run_i,
   input  wire logic bclk_run_i,
   output logic      hclk_o,
   output logic      bclk_o,
   output logic      fs_o
);
   int bit_cnt;
   // ==========================================================================
   // Clock sources, standing still low outside bursts
   initial begin
      hclk_o = 1'b0;
      forever #25 hclk_o = hclk_run_i ? ~hclk_o : 1'b0;
   end
   initial begin
      bclk_o = 1'b0;
      fs_o = 1'b0;
      bit_cnt = 0;
      forever begin
         #50 bclk_o = bclk_run_i ? ~bclk_o : 1'b0;
         // Frame sync only ever comes with our own bit clock
         if (bclk_run_i && !bclk_o) begin
            bit_cnt = (bit_cnt + 1) % 8;
            fs_o = (bit_cnt == 0);
         end else if (!bclk_run_i) begin
            fs_o = 1'b0;
         end
      end
   end
endmodule

// ==== apc_pkg.sv ====
// Package: register map, field layout, reset values and configuration carrier.
// Assumes a single 200 MHz peripheral clock and a simple strobe register port.
package apc_pkg;

   // ==========================================================================
   // Register map (byte offsets)
   localparam logic [7:0] OFF_PDIR     = 8'h00;
   localparam logic [7:0] OFF_TX_HCTL  = 8'h04;
   localparam logic [7:0] OFF_TX_BCTL  = 8'h08;
   localparam logic [7:0] OFF_RX_HCTL  = 8'h0C;
   localparam logic [7:0] OFF_RX_BCTL  = 8'h10;
   localparam logic [7:0] OFF_FRAME    = 8'h14;
   localparam logic [7:0] OFF_CLKCHK   = 8'h18;
   localparam logic [7:0] OFF_STATUS   = 8'h1C;

   // ==========================================================================
   // Field positions and widths
   localparam int PD_TX_BCLK   = 26;
   localparam int PD_TX_HCLK   = 27;
   localparam int PD_TX_FS     = 28;
   localparam int PD_RX_BCLK   = 29;
   localparam int PD_RX_HCLK   = 30;
   localparam int PD_RX_FS     = 31;
   localparam int HCLK_SRC_BIT = 15;
   localparam int HDIV_W       = 12;
   localparam int BCLK_SRC_BIT = 5;
   localparam int BDIV_W       = 5;
   localparam int FS_LEN_W     = 8;
   localparam int RX_FS_LSB    = 8;
   localparam int CHK_W        = 16;
   localparam int ST_TX_FAIL   = 0;
   localparam int ST_RX_FAIL   = 1;
   localparam int ST_PIN_LSB   = 8;
   localparam int NUM_SYNC     = 7;

   // ==========================================================================
   // Reset values
   localparam logic [31:0]         PDIR_RST   = 32'h0000_0000;
   localparam logic [31:0]         HCTL_RST   = 32'h0000_0000;
   localparam logic [31:0]         BCTL_RST   = 32'h0000_0000;
   localparam logic [FS_LEN_W-1:0] FS_LEN_RST = 8'h1F;
   localparam logic [CHK_W-1:0]    CHK_RST    = 16'h0100;

   typedef struct packed {
      logic                hclk_int;
      logic [HDIV_W-1:0]   hdiv;
      logic                bclk_int;
      logic [BDIV_W-1:0]   bdiv;
      logic [FS_LEN_W-1:0] fs_len;
   } apc_side_cfg_t;

   function automatic apc_side_cfg_t apc_cfg_f(input logic [31:0]         hctl,
                                               input logic [31:0]         bctl,
                                               input logic [FS_LEN_W-1:0] len);
      apc_side_cfg_t c;
      c.hclk_int = hctl[HCLK_SRC_BIT];
      c.hdiv     = hctl[HDIV_W-1:0];
      c.bclk_int = bctl[BCLK_SRC_BIT];
      c.bdiv     = bctl[BDIV_W-1:0];
      c.fs_len   = len;
      return c;
   endfunction

endpackage

// ==== apc_side_gen.sv ====
// Two-stage clock divider and frame sync generator for one side of the port.
// Assumes all tick inputs are one-cycle pulses on sys_clk_i.
`timescale 1ns/1ps
module apc_side_gen
   import apc_pkg::*;
(
   input  wire logic          sys_clk_i,
   input  wire logic          rst_b_i,
   input  wire apc_side_cfg_t cfg_i,
   input  wire logic          aux_tick_i,
   input  wire logic          hpin_tick_i,
   input  wire logic          bpin_tick_i,
   output logic               hclk_o,
   output logic               bclk_o,
   output logic               fs_o,
   output logic               bclk_tick_o
);

   logic [HDIV_W-1:0]   hcnt_reg;
   logic [BDIV_W-1:0]   bcnt_reg;
   logic [FS_LEN_W-1:0] fcnt_reg;
   logic                src_tick;
   logic                hclk_tick;
   logic                bgen_tick;

   // ==========================================================================
   // High clock stage
   assign src_tick  = cfg_i.hclk_int ? aux_tick_i : hpin_tick_i;
   assign hclk_tick = src_tick && (hcnt_reg >= cfg_i.hdiv);

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         hcnt_reg <= '0;
         hclk_o   <= 1'b0;
      end else if (src_tick) begin
         hcnt_reg <= hclk_tick ? '0 : hcnt_reg + 1'b1;
         // Divide by one leaves a steady high level; ticks still run at source rate
         hclk_o   <= hclk_tick ? 1'b1 : ((hcnt_reg + 1'b1) <= (cfg_i.hdiv >> 1));
      end
   end

   // ==========================================================================
   // Bit clock stage, fed only by the high clock stage when internal
   assign bgen_tick   = cfg_i.bclk_int && hclk_tick && (bcnt_reg >= cfg_i.bdiv);
   assign bclk_tick_o = cfg_i.bclk_int ? bgen_tick : bpin_tick_i;

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         bcnt_reg <= '0;
         bclk_o   <= 1'b0;
      end else if (cfg_i.bclk_int && hclk_tick) begin
         bcnt_reg <= bgen_tick ? '0 : bcnt_reg + 1'b1;
         bclk_o   <= bgen_tick ? 1'b1 : ((bcnt_reg + 1'b1) <= (cfg_i.bdiv >> 1));
      end
   end

   // ==========================================================================
   // Frame sync: one bit period wide every fs_len+1 bits
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         fcnt_reg <= '0;
         fs_o     <= 1'b0;
      end else if (!cfg_i.bclk_int) begin
         fcnt_reg <= '0;
         fs_o     <= 1'b0;
      end else if (bgen_tick) begin
         fcnt_reg <= (fcnt_reg >= cfg_i.fs_len) ? '0 : fcnt_reg + 1'b1;
         fs_o     <= (fcnt_reg == '0);
      end
   end

   // ==========================================================================
   // Checks
   hdiv_bound_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      hclk_tick |=> hcnt_reg == '0)
      else $error("high clock counter did not wrap");
   hsrc_sel_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      hclk_tick && !cfg_i.hclk_int |-> hpin_tick_i)
      else $error("external high clock tick without pin edge");
   int_chain_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      bclk_tick_o && cfg_i.bclk_int |-> hclk_tick && (cfg_i.hclk_int ? aux_tick_i : 1'b1))
      else $error("bit clock tick not caused by high clock stage");
   ext_hclk_fs_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      bgen_tick && fcnt_reg == '0 && cfg_i.bclk_int |=> fs_o)
      else $error("frame sync missing at frame start");

endmodule

// ==== apc_top.sv ====
// Clock generation and pin direction control for both sides of an audio serial port.
// Assumes pins and the auxiliary clock are asynchronous; a pad ring resolves pin enables.
`timescale 1ns/1ps
module apc_top
   import apc_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        rst_b_i,
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [31:0] reg_rdata_o,
   input  wire logic        aux_clk_i,
   input  wire logic        tx_frame_sync_pin_i,
   output logic             tx_frame_sync_pin_o,
   output logic             tx_frame_sync_pin_oe_o,
   input  wire logic        tx_high_clock_pin_i,
   output logic             tx_high_clock_pin_o,
   output logic             tx_high_clock_pin_oe_o,
   input  wire logic        tx_bit_clock_pin_i,
   output logic             tx_bit_clock_pin_o,
   output logic             tx_bit_clock_pin_oe_o,
   input  wire logic        rx_frame_sync_pin_i,
   output logic             rx_frame_sync_pin_o,
   output logic             rx_frame_sync_pin_oe_o,
   input  wire logic        rx_high_clock_pin_i,
   output logic             rx_high_clock_pin_o,
   output logic             rx_high_clock_pin_oe_o,
   input  wire logic        rx_bit_clock_pin_i,
   output logic             rx_bit_clock_pin_o,
   output logic             rx_bit_clock_pin_oe_o,
   output logic             tx_clk_fail_o,
   output logic             rx_clk_fail_o
);

   // ==========================================================================
   // Register state
   logic [31:0]         pdir_reg;
   logic [31:0]         tx_hctl_reg;
   logic [31:0]         tx_bctl_reg;
   logic [31:0]         rx_hctl_reg;
   logic [31:0]         rx_bctl_reg;
   logic [FS_LEN_W-1:0] tx_fs_len_reg;
   logic [FS_LEN_W-1:0] rx_fs_len_reg;
   logic [CHK_W-1:0]    chk_thr_reg;
   logic [1:0]          fail_reg;
   logic [31:0]         rdata_next;

   logic wr_pdir;
   logic wr_status;

   assign wr_pdir   = reg_wr_i && (reg_addr_i == OFF_PDIR);
   assign wr_status = reg_wr_i && (reg_addr_i == OFF_STATUS);

   // ==========================================================================
   // Pin synchronisers
   // Index 0 aux clock, 1..3 transmit high/bit/frame, 4..6 receive high/bit/frame
   logic [NUM_SYNC-1:0] sync1_reg;
   logic [NUM_SYNC-1:0] sync2_reg;
   logic [NUM_SYNC-1:0] sync3_reg;
   logic [NUM_SYNC-1:0] rise;
   logic [NUM_SYNC-1:0] raw_in;

   assign raw_in = {rx_frame_sync_pin_i, rx_bit_clock_pin_i, rx_high_clock_pin_i,
                    tx_frame_sync_pin_i, tx_bit_clock_pin_i, tx_high_clock_pin_i,
                    aux_clk_i};

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         sync3_reg <= '0;
      end else begin
         sync1_reg <= raw_in;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   // Edge detect reads only the settled stages
   assign rise = sync2_reg & ~sync3_reg;

   // ==========================================================================
   // Configuration registers
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pdir_reg <= PDIR_RST;
      end else if (wr_pdir) begin
         pdir_reg <= reg_wdata_i;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tx_hctl_reg <= HCTL_RST;
         tx_bctl_reg <= BCTL_RST;
         rx_hctl_reg <= HCTL_RST;
         rx_bctl_reg <= BCTL_RST;
      end else if (reg_wr_i) begin
         unique case (reg_addr_i)
            OFF_TX_HCTL: tx_hctl_reg <= reg_wdata_i;
            OFF_TX_BCTL: tx_bctl_reg <= reg_wdata_i;
            OFF_RX_HCTL: rx_hctl_reg <= reg_wdata_i;
            OFF_RX_BCTL: rx_bctl_reg <= reg_wdata_i;
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tx_fs_len_reg <= FS_LEN_RST;
         rx_fs_len_reg <= FS_LEN_RST;
         chk_thr_reg   <= CHK_RST;
      end else if (reg_wr_i && reg_addr_i == OFF_FRAME) begin
         tx_fs_len_reg <= reg_wdata_i[FS_LEN_W-1:0];
         rx_fs_len_reg <= reg_wdata_i[RX_FS_LSB+FS_LEN_W-1:RX_FS_LSB];
      end else if (reg_wr_i && reg_addr_i == OFF_CLKCHK) begin
         chk_thr_reg <= reg_wdata_i[CHK_W-1:0];
      end
   end

   // ==========================================================================
   // Per-side generators and clock failure watchdogs
   apc_side_cfg_t    side_cfg [2];
   logic [1:0]       gen_hclk;
   logic [1:0]       gen_bclk;
   logic [1:0]       gen_fs;
   logic [1:0]       bclk_tick;
   logic [1:0]       fail_evt;
   logic [CHK_W-1:0] wd_cnt_reg [2];

   assign side_cfg[0] = apc_cfg_f(tx_hctl_reg, tx_bctl_reg, tx_fs_len_reg);
   assign side_cfg[1] = apc_cfg_f(rx_hctl_reg, rx_bctl_reg, rx_fs_len_reg);

   genvar s;
   generate
      for (s = 0; s < 2; s++) begin : g_side
         apc_side_gen u_gen (
            .sys_clk_i   (sys_clk_i),
            .rst_b_i     (rst_b_i),
            .cfg_i       (side_cfg[s]),
            .aux_tick_i  (rise[0]),
            .hpin_tick_i (rise[1+3*s]),
            .bpin_tick_i (rise[2+3*s]),
            .hclk_o      (gen_hclk[s]),
            .bclk_o      (gen_bclk[s]),
            .fs_o        (gen_fs[s]),
            .bclk_tick_o (bclk_tick[s])
         );

         // A stalled bit clock, e.g. a partner giving frame sync without one, trips this
         // Saturating compare, so a lowered threshold still trips at once
         assign fail_evt[s] = (chk_thr_reg != '0) && !bclk_tick[s]
                              && (wd_cnt_reg[s] >= chk_thr_reg);

         always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               wd_cnt_reg[s] <= '0;
            end else if (bclk_tick[s] || chk_thr_reg == '0) begin
               wd_cnt_reg[s] <= '0;
            end else if (wd_cnt_reg[s] < chk_thr_reg) begin
               wd_cnt_reg[s] <= wd_cnt_reg[s] + 1'b1;
            end
         end

         // Set beats a write-one clear in the same cycle
         always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               fail_reg[s] <= 1'b0;
            end else if (fail_evt[s]) begin
               fail_reg[s] <= 1'b1;
            end else if (wr_status && reg_wdata_i[ST_TX_FAIL+s]) begin
               fail_reg[s] <= 1'b0;
            end
         end
      end
   endgenerate

   assign tx_clk_fail_o = fail_reg[ST_TX_FAIL];
   assign rx_clk_fail_o = fail_reg[ST_RX_FAIL];

   // ==========================================================================
   // Pin drivers
   // Levels are produced whether or not the driver is enabled, so master timing
   // can run with quiet pins
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tx_high_clock_pin_o <= 1'b0;
         tx_bit_clock_pin_o  <= 1'b0;
         tx_frame_sync_pin_o <= 1'b0;
         rx_high_clock_pin_o <= 1'b0;
         rx_bit_clock_pin_o  <= 1'b0;
         rx_frame_sync_pin_o <= 1'b0;
      end else begin
         tx_high_clock_pin_o <= gen_hclk[0];
         tx_bit_clock_pin_o  <= gen_bclk[0];
         tx_frame_sync_pin_o <= gen_fs[0];
         rx_high_clock_pin_o <= gen_hclk[1];
         rx_bit_clock_pin_o  <= gen_bclk[1];
         rx_frame_sync_pin_o <= gen_fs[1];
      end
   end

   // Enables come straight from the direction register bits
   assign tx_bit_clock_pin_oe_o  = pdir_reg[PD_TX_BCLK];
   assign tx_high_clock_pin_oe_o = pdir_reg[PD_TX_HCLK];
   assign tx_frame_sync_pin_oe_o = pdir_reg[PD_TX_FS];
   assign rx_bit_clock_pin_oe_o  = pdir_reg[PD_RX_BCLK];
   assign rx_high_clock_pin_oe_o = pdir_reg[PD_RX_HCLK];
   assign rx_frame_sync_pin_oe_o = pdir_reg[PD_RX_FS];

   // ==========================================================================
   // Read port: data stand one cycle after the strobe, zero otherwise
   always_comb begin
      rdata_next = '0;
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            OFF_PDIR:    rdata_next = pdir_reg;
            OFF_TX_HCTL: rdata_next = tx_hctl_reg;
            OFF_TX_BCTL: rdata_next = tx_bctl_reg;
            OFF_RX_HCTL: rdata_next = rx_hctl_reg;
            OFF_RX_BCTL: rdata_next = rx_bctl_reg;
            OFF_FRAME: begin
               rdata_next[FS_LEN_W-1:0]                    = tx_fs_len_reg;
               rdata_next[RX_FS_LSB+FS_LEN_W-1:RX_FS_LSB] = rx_fs_len_reg;
            end
            OFF_CLKCHK:  rdata_next[CHK_W-1:0] = chk_thr_reg;
            OFF_STATUS: begin
               rdata_next[ST_RX_FAIL:ST_TX_FAIL]            = fail_reg;
               rdata_next[ST_PIN_LSB+NUM_SYNC-2:ST_PIN_LSB] = sync2_reg[NUM_SYNC-1:1];
            end
            default:     rdata_next = '0;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         reg_rdata_o <= '0;
      end else begin
         reg_rdata_o <= rdata_next;
      end
   end

   // ==========================================================================
   // Checks
   pdir_oe_follow_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      wr_pdir |=> tx_bit_clock_pin_oe_o == $past(reg_wdata_i[PD_TX_BCLK])
                  && rx_frame_sync_pin_oe_o == $past(reg_wdata_i[PD_RX_FS])
                  && tx_high_clock_pin_oe_o == $past(reg_wdata_i[PD_TX_HCLK]))
      else $error("pin enable does not follow direction write");

   tx_master_dir_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      wr_pdir && reg_wdata_i == 32'h1C00_0000 |=>
         {tx_frame_sync_pin_oe_o, tx_high_clock_pin_oe_o, tx_bit_clock_pin_oe_o} == 3'h7
         && {rx_frame_sync_pin_oe_o, rx_high_clock_pin_oe_o, rx_bit_clock_pin_oe_o} == 3'h0)
      else $error("transmit master direction wrong");

   all_input_dir_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      wr_pdir && reg_wdata_i == 32'h0000_0000 |=>
         !(tx_frame_sync_pin_oe_o || tx_high_clock_pin_oe_o || tx_bit_clock_pin_oe_o
           || rx_frame_sync_pin_oe_o || rx_high_clock_pin_oe_o || rx_bit_clock_pin_oe_o))
      else $error("a pin still driven after all-input direction");

   ext_hclk_dir_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      wr_pdir && reg_wdata_i == 32'h1400_0000 |=>
         !tx_high_clock_pin_oe_o && tx_frame_sync_pin_oe_o && tx_bit_clock_pin_oe_o)
      else $error("external high clock direction wrong");

   quiet_master_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      $rose(gen_bclk[0]) |=> tx_bit_clock_pin_o)
      else $error("generated bit clock not presented at pin output");

   fail_set_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      fail_evt[0] |=> tx_clk_fail_o [*2])
      else $error("clock failure flag not set and held");

   unmapped_read_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      reg_rd_i && reg_addr_i > OFF_STATUS |=> reg_rdata_o == 32'h0000_0000)
      else $error("unmapped read returned data");

   aux_source_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      $rose(gen_hclk[0]) && side_cfg[0].hclk_int |-> $past(rise[0]))
      else $error("internal high clock edge without auxiliary edge");

   rx_aux_source_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      $rose(gen_hclk[1]) && side_cfg[1].hclk_int |-> $past(rise[0]))
      else $error("receive high clock edge without auxiliary edge");

   ext_source_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      $rose(gen_hclk[0]) && !side_cfg[0].hclk_int |-> $past(rise[1]))
      else $error("external high clock edge without pin edge");

   pin_level_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      tx_high_clock_pin_o == $past(gen_hclk[0]) && tx_bit_clock_pin_o == $past(gen_bclk[0])
      && tx_frame_sync_pin_o == $past(gen_fs[0])
      && rx_bit_clock_pin_o == $past(gen_bclk[1]))
      else $error("pin output does not follow its generator");

   pdir_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      !wr_pdir |=> $stable(pdir_reg))
      else $error("direction changed without a write");

   rd_data_once_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      !reg_rd_i |=> reg_rdata_o == 32'h0000_0000)
      else $error("read data stood longer than one cycle");

   status_rd_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      reg_rd_i && reg_addr_i == OFF_STATUS |=> reg_rdata_o[ST_TX_FAIL] == $past(tx_clk_fail_o))
      else $error("status read lost the failure flag");

   frame_rd_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      reg_rd_i && reg_addr_i == OFF_FRAME |=> reg_rdata_o[31:16] == 16'h0000)
      else $error("frame length read has stray upper bits");

   rx_fail_set_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      fail_evt[1] |=> rx_clk_fail_o)
      else $error("receive clock failure flag not set");

   fail_clear_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      wr_status && reg_wdata_i[ST_TX_FAIL] && !fail_evt[0] |=> !tx_clk_fail_o)
      else $error("write one did not clear the failure flag");

   fail_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      rx_clk_fail_o && !(wr_status && reg_wdata_i[ST_RX_FAIL]) |=> rx_clk_fail_o)
      else $error("failure flag dropped without a clear");

   wd_cap_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      wd_cnt_reg[0] <= chk_thr_reg |=> wd_cnt_reg[0] <= chk_thr_reg || $changed(chk_thr_reg))
      else $error("watchdog counter ran past its threshold");

   master_run_c: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      side_cfg[0].bclk_int && side_cfg[0].hclk_int && $rose(tx_frame_sync_pin_o));
   ext_hclk_run_c: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      side_cfg[0].bclk_int && !side_cfg[0].hclk_int && $rose(tx_bit_clock_pin_o));
   clk_fail_c: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      $rose(rx_clk_fail_o));
   fail_clear_c: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      $fell(tx_clk_fail_o));
   slave_clock_c: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      !side_cfg[0].bclk_int && bclk_tick[0]);

endmodule

// ==== apc_top_test.sv ====
// Testbench: register port, pin direction, divider and clock failure checks.
// Assumes the codec model drives transmit pins whenever the port leaves them undriven.
`timescale 1ns/1ps
module apc_top_test
   import apc_pkg::*;
;
   logic        clk, rst_b, wr, rd, aux, aux_run, h_run, b_run;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata, rv;
   logic        fs_o, fs_oe, hc_o, hc_oe, bc_o, bc_oe, m_h, m_b, m_f, tx_fail, rx_fail;
   logic [2:0]  rx_o, rx_oe;
   int          num_errors, checks, cyc, hc, bc, rhc, rbc, fsc;
   // ==========================================================================
   // Design, partner and resolved pins
   apc_top apc_top_i (.sys_clk_i(clk), .rst_b_i(rst_b), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .aux_clk_i(aux), .tx_frame_sync_pin_i(fs_oe ? fs_o : m_f),
      .tx_frame_sync_pin_o(fs_o), .tx_frame_sync_pin_oe_o(fs_oe),
      .tx_high_clock_pin_i(hc_oe ? hc_o : m_h), .tx_high_clock_pin_o(hc_o),
      .tx_high_clock_pin_oe_o(hc_oe), .tx_bit_clock_pin_i(bc_oe ? bc_o : m_b),
      .tx_bit_clock_pin_o(bc_o), .tx_bit_clock_pin_oe_o(bc_oe),
      .rx_frame_sync_pin_i(1'b0), .rx_frame_sync_pin_o(rx_o[2]),
      .rx_frame_sync_pin_oe_o(rx_oe[2]), .rx_high_clock_pin_i(1'b0),
      .rx_high_clock_pin_o(rx_o[1]), .rx_high_clock_pin_oe_o(rx_oe[1]),
      .rx_bit_clock_pin_i(1'b0), .rx_bit_clock_pin_o(rx_o[0]),
      .rx_bit_clock_pin_oe_o(rx_oe[0]), .tx_clk_fail_o(tx_fail), .rx_clk_fail_o(rx_fail));
   apc_codec_model apc_codec_model_i (.hclk_run_i(h_run), .bclk_run_i(b_run),
      .hclk_o(m_h), .bclk_o(m_b), .fs_o(m_f));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Aux period 40 ns keeps each level well above two system cycles
   initial begin
      aux = 1'b0;
      forever #20 aux = aux_run ? ~aux : 1'b0;
   end
   always @(posedge hc_o) hc++;
   always @(posedge bc_o) bc++;
   always @(posedge rx_o[1]) rhc++;
   always @(posedge rx_o[0]) rbc++;
   always @(posedge fs_o) fsc++;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         stop_test();
      end
   end
   // ==========================================================================
   // Access and compare tasks
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 rv = rdata;
   endtask
   task automatic chk(input logic [31:0] e, input logic [31:0] a);
      checks++;
      if (a !== e) begin
         num_errors++;
         $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, a);
      end
   endtask
   task automatic chk_rng(input int lo, input int hi, input int n);
      checks++;
      if (n < lo || n > hi) begin
         num_errors++;
         $display("CHECK FAILED t=%0t exp=%h..%h got=%h", $time, lo, hi, n);
      end
   endtask
   task automatic pd(input logic [31:0] d);
      wr_reg(OFF_PDIR, d);
      @(posedge clk);
      #1 chk({26'h0, d[31:26]}, {26'h0, rx_oe[2], rx_oe[1], rx_oe[0], fs_oe, hc_oe, bc_oe});
      rd_reg(OFF_PDIR);
      chk(d, rv);
   endtask
   task automatic measure;
      hc = 0;
      bc = 0;
      rhc = 0;
      rbc = 0;
      fsc = 0;
      repeat (200) @(posedge clk);
   endtask
   task automatic stop_test;
      $display("Summary: %0d checks, %0d mismatches", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // ==========================================================================
   // Test sequence
   initial begin
      {rst_b, wr, rd, aux_run, h_run, b_run, addr, wdata} = '0;
      {num_errors, checks, cyc} = '0;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      rd_reg(OFF_PDIR);
      chk(PDIR_RST, rv);
      rd_reg(OFF_CLKCHK);
      chk({16'h0000, CHK_RST}, rv);
      pd(32'h1C00_0000);
      pd(32'h1400_0000);
      pd(32'hFC00_0000);
      pd(32'h0000_0000);
      wr_reg(8'hE0, 32'hFFFF_FFFF);
      rd_reg(8'hE0);
      chk(32'h0000_0000, rv);
      $display("Test reset and direction done");
      // Generators run as master while every pin stays undriven
      wr_reg(OFF_TX_HCTL, 32'h0000_8001);
      wr_reg(OFF_TX_BCTL, 32'h0000_0021);
      wr_reg(OFF_RX_HCTL, 32'h0000_8003);
      wr_reg(OFF_RX_BCTL, 32'h0000_0021);
      wr_reg(OFF_FRAME, 32'h0000_0101);
      rd_reg(OFF_FRAME);
      chk(32'h0000_0101, rv);
      aux_run = 1'b1;
      measure();
      chk_rng(11, 14, hc);
      chk_rng(5, 7, bc);
      chk_rng(5, 7, rhc);
      chk_rng(2, 4, rbc);
      chk_rng(2, 4, fsc);
      $display("Test internal clocks done");
      aux_run = 1'b0;
      pd(32'h1400_0000);
      wr_reg(OFF_TX_HCTL, 32'h0000_0001);
      h_run = 1'b1;
      measure();
      chk_rng(9, 11, hc);
      chk_rng(4, 6, bc);
      chk_rng(2, 4, fsc);
      $display("Test external high clock done");
      h_run = 1'b0;
      pd(32'h0000_0000);
      wr_reg(OFF_TX_HCTL, 32'h0000_0000);
      wr_reg(OFF_TX_BCTL, 32'h0000_0000);
      wr_reg(OFF_CLKCHK, 32'h0000_0020);
      wr_reg(OFF_STATUS, 32'h0000_0003);
      repeat (60) @(posedge clk);
      #1 chk(32'h3, {30'h0, rx_fail, tx_fail});
      rd_reg(OFF_STATUS);
      chk(32'h0000_0003, rv);
      b_run = 1'b1;
      repeat (40) @(posedge clk);
      wr_reg(OFF_STATUS, 32'h0000_0001);
      repeat (100) @(posedge clk);
      #1 chk(32'h2, {30'h0, rx_fail, tx_fail});
      $display("Test clock failure done");
      stop_test();
   end
endmodule
